// [hdl/fan_floor_policy.sv]
`timescale 1ns/1ps
`include "fan_floor_defines.svh"

module fan_floor_policy #(
  parameter int PWM_DIV = `PWM_DIV_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] below_tmin,
  input wire logic [2:0][7:0] auto_duty,
  output logic fan_drive_out_1,
  output logic fan_drive_out_2,
  output logic fan_drive_out_3
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic fan_floor_pkg::reg_sel_t decode(input logic [7:0] idx);
    fan_floor_pkg::reg_sel_t s;
    s = fan_floor_pkg::SEL_NONE;
    if (idx == `IDX_RAMP2) s = fan_floor_pkg::SEL_RAMP2;
    else if (idx == `IDX_CFG1) s = fan_floor_pkg::SEL_CFG1;
    else if (idx == `IDX_AUTO) s = fan_floor_pkg::SEL_AUTO;
    else if (idx == `IDX_STAT) s = fan_floor_pkg::SEL_STAT;
    else if (idx[7:2] == 6'(`IDX_MIN_BASE >> 2) && idx[1:0] != 2'h3) s = fan_floor_pkg::SEL_MIN;
    else if (idx[7:2] == 6'(`IDX_MAN_BASE >> 2) && idx[1:0] != 2'h3) s = fan_floor_pkg::SEL_MAN;
    return s;
  endfunction

  logic acc;
  fan_floor_pkg::ahb_req_t req_ff, nxt_req;
  fan_floor_pkg::reg_sel_t wsel, rsel;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && htrans[1] && hready && hsize == 3'h2 && haddr[1:0] == 2'h0 && haddr[31:10] == 22'h0;
  assign wsel = (req_ff.hit && req_ff.wr) ? decode(req_ff.idx) : fan_floor_pkg::SEL_NONE;
  assign rsel = (acc && !hwrite) ? decode(haddr[9:2]) : fan_floor_pkg::SEL_NONE;

  always_comb begin
    nxt_req = req_ff;
    if (hready) begin
      nxt_req.hit = acc;
      nxt_req.wr = hwrite;
      nxt_req.idx = haddr[9:2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_ff <= '0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] ramp2_ff, nxt_ramp2;
  logic lock_ff, nxt_lock;
  logic [2:0] auto_en_ff, nxt_auto_en;
  fan_floor_pkg::duty_t [2:0] min_duty_ff, nxt_min_duty;
  fan_floor_pkg::duty_t [2:0] man_duty_ff, nxt_man_duty;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [2:0] floor_act;
  logic [2:0] floor_sel;

  assign floor_sel = ramp2_ff[`FLOOR_SEL_LSB +: 3];

  always_comb begin
    nxt_ramp2 = ramp2_ff;
    nxt_lock = lock_ff;
    nxt_auto_en = auto_en_ff;
    nxt_min_duty = min_duty_ff;
    nxt_man_duty = man_duty_ff;
    unique case (wsel)
      fan_floor_pkg::SEL_RAMP2: begin
        if (!lock_ff) nxt_ramp2 = hwdata[7:0];
      end
      fan_floor_pkg::SEL_CFG1: begin
        if (hwdata[`LOCK_BIT]) nxt_lock = 1'b1;
      end
      fan_floor_pkg::SEL_AUTO: nxt_auto_en = hwdata[2:0];
      fan_floor_pkg::SEL_MIN: nxt_min_duty[req_ff.idx[1:0]] = hwdata[7:0];
      fan_floor_pkg::SEL_MAN: nxt_man_duty[req_ff.idx[1:0]] = hwdata[7:0];
      fan_floor_pkg::SEL_NONE, fan_floor_pkg::SEL_STAT: begin
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    nxt_hrdata = hrdata_ff;
    if (acc) nxt_hrdata = 32'h0;
    unique case (rsel)
      fan_floor_pkg::SEL_RAMP2: nxt_hrdata = {24'h0, nxt_ramp2};
      fan_floor_pkg::SEL_CFG1: nxt_hrdata = {30'h0, nxt_lock, 1'b0};
      fan_floor_pkg::SEL_AUTO: nxt_hrdata = {29'h0, nxt_auto_en};
      fan_floor_pkg::SEL_MIN: nxt_hrdata = {24'h0, nxt_min_duty[haddr[3:2]]};
      fan_floor_pkg::SEL_MAN: nxt_hrdata = {24'h0, nxt_man_duty[haddr[3:2]]};
      fan_floor_pkg::SEL_STAT: nxt_hrdata = {26'h0, floor_act, below_tmin};
      fan_floor_pkg::SEL_NONE: begin
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ramp2_ff <= `RAMP2_RST;
      lock_ff <= 1'b0;
      auto_en_ff <= `AUTO_RST;
      min_duty_ff <= '0;
      man_duty_ff <= '0;
      hrdata_ff <= 32'h0;
    end else begin
      ramp2_ff <= nxt_ramp2;
      lock_ff <= nxt_lock;
      auto_en_ff <= nxt_auto_en;
      min_duty_ff <= nxt_min_duty;
      man_duty_ff <= nxt_man_duty;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign hrdata = hrdata_ff;

  // ****************************************
  // Duty selection per channel
  // ****************************************
  fan_floor_pkg::duty_t [2:0] duty_ff, nxt_duty;

  for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
    assign floor_act[i] = auto_en_ff[i] && below_tmin[i];
    always_comb begin
      if (floor_act[i]) begin
        nxt_duty[i] = floor_sel[i] ? min_duty_ff[i] : `DUTY_RST;
      end else if (auto_en_ff[i]) begin
        nxt_duty[i] = auto_duty[i];
      end else begin
        nxt_duty[i] = man_duty_ff[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      duty_ff <= '0;
    end else begin
      duty_ff <= nxt_duty;
    end
  end

  // ****************************************
  // PWM generator
  // ****************************************
  logic [15:0] div_ff, nxt_div;
  logic step;
  logic [7:0] pwm_cnt_ff, nxt_pwm_cnt;
  logic [2:0] out_ff, nxt_out;

  assign step = div_ff == 16'(PWM_DIV - 1);

  always_comb begin
    nxt_div = step ? 16'h0 : div_ff + 16'h1;
    nxt_pwm_cnt = pwm_cnt_ff;
    if (step) nxt_pwm_cnt = (pwm_cnt_ff == `PWM_PERIOD - 8'h1) ? 8'h0 : pwm_cnt_ff + 8'h1;
    for (int k = 0; k < `NUM_CH; k++) begin
      nxt_out[k] = duty_ff[k] > pwm_cnt_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 16'h0;
      pwm_cnt_ff <= 8'h0;
      out_ff <= 3'h0;
    end else begin
      div_ff <= nxt_div;
      pwm_cnt_ff <= nxt_pwm_cnt;
      out_ff <= nxt_out;
    end
  end

  assign fan_drive_out_1 = out_ff[0];
  assign fan_drive_out_2 = out_ff[1];
  assign fan_drive_out_3 = out_ff[2];

  // ****************************************
  // Period audit
  // ****************************************
  logic wrap;
  logic wrap_ff, nxt_wrap;
  logic [2:0] dirty_ff, nxt_dirty;
  fan_floor_pkg::duty_t [2:0] duty_dly_ff, nxt_duty_dly;
  logic [2:0][15:0] hi_cnt_ff, nxt_hi_cnt;

  assign wrap = step && pwm_cnt_ff == `PWM_PERIOD - 8'h1;

  always_comb begin
    nxt_wrap = wrap;
    nxt_duty_dly = duty_ff;
    for (int k = 0; k < `NUM_CH; k++) begin
      if (wrap_ff) begin
        nxt_dirty[k] = 1'b0;
        nxt_hi_cnt[k] = 16'h0;
      end else begin
        nxt_dirty[k] = dirty_ff[k] || duty_ff[k] != duty_dly_ff[k];
        nxt_hi_cnt[k] = hi_cnt_ff[k] + 16'(out_ff[k]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrap_ff <= 1'b0;
      dirty_ff <= 3'h7;
      duty_dly_ff <= '0;
      hi_cnt_ff <= '0;
    end else begin
      wrap_ff <= nxt_wrap;
      dirty_ff <= nxt_dirty;
      duty_dly_ff <= nxt_duty_dly;
      hi_cnt_ff <= nxt_hi_cnt;
    end
  end

  for (genvar i = 0; i < `NUM_CH; i++) begin : g_audit
    period_duty_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      wrap_ff && !dirty_ff[i] |-> hi_cnt_ff[i] + 16'(out_ff[i]) == 16'(duty_dly_ff[i]) * 16'(PWM_DIV))
      else $error("high time differs from duty");
    floor_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      floor_act[i] && floor_sel[i] |=> duty_ff[i] == $past(min_duty_ff[i]))
      else $error("minimum duty not held below floor");
    off_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      floor_act[i] && !floor_sel[i] |-> ##2 !out_ff[i])
      else $error("output high while channel is off");
    auto_pass_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      auto_en_ff[i] && !below_tmin[i] |=> duty_ff[i] == $past(auto_duty[i]))
      else $error("automatic duty not applied");
    manual_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !auto_en_ff[i] |=> duty_ff[i] == $past(man_duty_ff[i]))
      else $error("manual duty not held");
    cover_audit_c: cover property (@(posedge ref_clk) disable iff (!rstn)
      wrap_ff && !dirty_ff[i] && duty_dly_ff[i] != 8'h00);
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  floor_ch1_a: assert property (auto_en_ff[0] && below_tmin[0] |=>
    duty_ff[0] == ($past(floor_sel[0]) ? $past(min_duty_ff[0]) : 8'h00))
    else $error("channel 1 floor duty wrong");
  floor_ch2_a: assert property (auto_en_ff[1] && below_tmin[1] |=>
    duty_ff[1] == ($past(floor_sel[1]) ? $past(min_duty_ff[1]) : 8'h00))
    else $error("channel 2 floor duty wrong");
  floor_ch3_a: assert property (auto_en_ff[2] && below_tmin[2] && !floor_sel[2] |=>
    duty_ff[2] == 8'h00 ##1 !fan_drive_out_3)
    else $error("channel 3 not off below floor");
  lock_hold_a: assert property (lock_ff |=> $stable(ramp2_ff) && lock_ff)
    else $error("locked register changed");
  manual_duty_a: assert property (!auto_en_ff[0] |=> duty_ff[0] == $past(man_duty_ff[0]))
    else $error("manual duty not applied");
  zero_out_a: assert property (duty_ff[1] == 8'h00 |=> !fan_drive_out_2)
    else $error("output high at zero duty");
  lock_block_a: assert property (wsel == fan_floor_pkg::SEL_RAMP2 && lock_ff |=>
    ramp2_ff == $past(ramp2_ff))
    else $error("write landed on locked register");
  write_lands_a: assert property (wsel == fan_floor_pkg::SEL_RAMP2 && !lock_ff |=>
    ramp2_ff == $past(hwdata[7:0]))
    else $error("write to open register lost");
  cfg_read_a: assert property (rsel == fan_floor_pkg::SEL_CFG1 && wsel != fan_floor_pkg::SEL_CFG1 |=>
    hrdata == {30'h0, $past(lock_ff), 1'b0})
    else $error("lock bit read back wrong");
  ramp_read_a: assert property (rsel == fan_floor_pkg::SEL_RAMP2 && wsel != fan_floor_pkg::SEL_RAMP2 |=>
    hrdata == {24'h0, $past(ramp2_ff)})
    else $error("floor select register read back wrong");
  auto_write_a: assert property (wsel == fan_floor_pkg::SEL_AUTO |=>
    auto_en_ff == $past(hwdata[2:0]))
    else $error("auto enable write lost");
  stat_read_a: assert property (rsel == fan_floor_pkg::SEL_STAT |=>
    hrdata == {26'h0, $past(auto_en_ff & below_tmin), $past(below_tmin)})
    else $error("status read back wrong");

  // ****************************************
  // Covers
  // ****************************************
  cover_manual_c: cover property (!auto_en_ff[1] && below_tmin[1]);
  cover_lock_c: cover property (!lock_ff ##1 lock_ff);
  cover_floor_c: cover property (floor_act[0] && floor_sel[0] ##1 duty_ff[0] != 8'h00);
  cover_pulse_c: cover property (!fan_drive_out_1 ##1 fan_drive_out_1);

endmodule

// [hdl/fan_floor_defines.svh]
// Overview of operation
// - Auto mode, channel 1 below floor: output 0% if select bit 0, else minimum duty.
// - Auto mode, channel 2 below floor: output 0% if select bit 0, else minimum duty.
// - Auto mode, channel 3 below floor: output 0% if select bit 0, else minimum duty.
// - After the lock bit is set, writes to the floor select register are ignored.
`ifndef FAN_FLOOR_DEFINES_SVH
`define FAN_FLOOR_DEFINES_SVH

// ****************************************
// Register indices, byte address is index times four
// ****************************************
`define IDX_RAMP2 8'h63
`define IDX_CFG1 8'h40
`define IDX_AUTO 8'h5C
`define IDX_MIN_BASE 8'h64
`define IDX_MAN_BASE 8'h30
`define IDX_STAT 8'h70

// ****************************************
// Fields and reset values
// ****************************************
`define FLOOR_SEL_LSB 5
`define LOCK_BIT 1
`define RAMP2_RST 8'h00
`define AUTO_RST 3'h0
`define DUTY_RST 8'h00
`define NUM_CH 3

// ****************************************
// Timing
// ****************************************
`define PWM_PERIOD 8'hFF
`define PWM_DIV_DEFAULT 4

`endif

// [hdl/fan_floor_pkg.sv]
package fan_floor_pkg;

  typedef logic [7:0] duty_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_RAMP2 = 3'h1,
    SEL_CFG1 = 3'h2,
    SEL_AUTO = 3'h3,
    SEL_MIN = 3'h4,
    SEL_MAN = 3'h5,
    SEL_STAT = 3'h6
  } reg_sel_t;

  typedef struct packed {
    logic hit;
    logic wr;
    logic [7:0] idx;
  } ahb_req_t;

endpackage

// [dv/fan_load_model.sv]
`timescale 1ns/1ps
// ****************************************
// Fan load: counts high cycles per PWM period
// ****************************************
module fan_load_model #(
  parameter int PERIOD = 255
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic drive,
  output logic [8:0] duty_seen,
  output logic seen_v
);
  logic [8:0] win_ff;
  logic [8:0] acc_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      win_ff <= 9'h000;
      acc_ff <= 9'h000;
      duty_seen <= 9'h000;
      seen_v <= 1'b0;
    end else begin
      seen_v <= (win_ff == 9'(PERIOD - 1));
      if (win_ff == 9'(PERIOD - 1)) begin
        win_ff <= 9'h000;
        acc_ff <= 9'h000;
        duty_seen <= acc_ff + 9'(drive);
      end else begin
        win_ff <= win_ff + 9'h001;
        acc_ff <= acc_ff + 9'(drive);
      end
    end
  end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "fan_floor_defines.svh"
// ****************************************
// Fan floor policy bench
// ****************************************
module tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [2:0] below_tmin = 3'h0;
  logic [2:0][7:0] auto_duty = 24'h0;
  logic [2:0] fo;
  logic [8:0] seen [3];
  logic [2:0] sv;
  logic rd_v = 1'b0;
  logic arm = 1'b0;
  logic [31:0] exp_q [$];
  int fail_count = 0;
  int total_checks = 0;
  int seed = 24;
  logic [7:0] mind [3];
  logic [7:0] man [3];
  logic [7:0] val = 8'h00;
  always #4 ref_clk = ~ref_clk;
  fan_floor_policy #(.PWM_DIV(1)) DUT (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .below_tmin(below_tmin),
    .auto_duty(auto_duty), .fan_drive_out_1(fo[0]), .fan_drive_out_2(fo[1]), .fan_drive_out_3(fo[2]));
  for (genvar i = 0; i < 3; i++) begin : g_fan
    fan_load_model FAN (.ref_clk(ref_clk), .rstn(rstn), .drive(fo[i]), .duty_seen(seen[i]), .seen_v(sv[i]));
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Single AHB transfer; a read queues its expected word
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_v <= !wr;
    if (!wr) exp_q.push_back(d);
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd_v <= 1'b0;
  endtask
  task automatic measure(input logic [2:0] en);
    logic [7:0] e;
    repeat (520) @(posedge ref_clk);
    for (int c = 0; c < 3; c++) begin
      if (!en[c]) e = man[c];
      else if (below_tmin[c]) e = val[5+c] ? mind[c] : 8'h00;
      else e = auto_duty[c];
      exp_q.push_back({24'h0, e});
    end
    arm <= 1'b1;
    @(posedge ref_clk);
    wait (arm === 1'b0);
  endtask
  always @(posedge ref_clk) begin
    if (rd_v && hreadyout) check(hrdata, exp_q.pop_front());
    if (rd_v && hreadyout) check({31'h0, hresp}, 32'h0);
    if (arm && sv[0]) begin
      for (int c = 0; c < 3; c++) check({23'h0, seen[c]}, exp_q.pop_front());
      arm <= 1'b0;
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    ahb(1'b0, `IDX_RAMP2, 32'h0);
    ahb(1'b0, 8'hFF, 32'h0);
    for (int c = 0; c < 3; c++) begin
      mind[c] = 8'($random(seed));
      man[c] = 8'($random(seed));
      ahb(1'b1, `IDX_MIN_BASE + 8'(c), {24'h0, mind[c]});
      ahb(1'b1, `IDX_MAN_BASE + 8'(c), {24'h0, man[c]});
    end
    ahb(1'b1, `IDX_AUTO, 32'h7);
    for (int i = 0; i < 8; i++) begin
      val = {3'(i), 5'($random(seed))};
      ahb(1'b1, `IDX_RAMP2, {24'h0, val});
      ahb(1'b0, `IDX_RAMP2, {24'h0, val});
      below_tmin <= 3'($random(seed));
      auto_duty <= 24'($random(seed));
      measure(3'h7);
    end
    below_tmin <= 3'h7;
    ahb(1'b1, `IDX_AUTO, 32'h5);
    measure(3'h5);
    // Lock, then a write that must not land
    ahb(1'b1, `IDX_CFG1, 32'h2);
    ahb(1'b0, `IDX_CFG1, 32'h2);
    ahb(1'b1, `IDX_RAMP2, {24'h0, ~val});
    ahb(1'b0, `IDX_RAMP2, {24'h0, val});
    below_tmin <= 3'h7;
    ahb(1'b1, `IDX_AUTO, 32'h7);
    measure(3'h7);
    ahb(1'b0, `IDX_STAT, 32'h3F);
    finish_test;
  end
  initial begin
    #400000;
    fail_count++;
    finish_test;
  end
endmodule
